// ### logic/cmow_pkg.sv
package cmow_pkg;
    // sfr addresses
    localparam logic [7:0] ADDR_PAGE = 8'hb1;
    localparam logic [7:0] ADDR_STATUS = 8'hb2;
    localparam logic [7:0] ADDR_CTRL = 8'hb3;
    localparam logic [7:0] ADDR_IDT_HIGH = 8'hbc;
    localparam logic [7:0] ADDR_IDT_LOW = 8'hbd;
    localparam logic [7:0] ADDR_DATA = 8'ha3;

    localparam int NUM_OBJ = 15;
    localparam int DATA_BYTES = 8;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam int PAGE_OBJ_LSB = 4;
    localparam int PAGE_INDEX_AUTOINC_N_BIT = 3;

    // control and length field positions
    localparam int CFG_LSB = 6;
    localparam int REPLY_VALID_BIT = 5;
    localparam int IDE_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] CFG_DISABLE = 2'h0;
    localparam logic [1:0] CFG_TX = 2'h1;
    localparam logic [1:0] CFG_RX = 2'h2;
    localparam logic [1:0] CFG_RXBUF = 2'h3;

    // status bit positions
    localparam int ST_LEN_WARN = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_RX_DONE = 5;
    localparam int ST_BIT_ERR = 4;
    localparam int ST_STUFF_ERR = 3;
    localparam int ST_CRC_ERR = 2;
    localparam int ST_FORM_ERR = 1;
    localparam int ST_ACK_ERR = 0;

    localparam int IDT_LOW_LSB = 5;
    localparam logic [2:0] STUFF_LIMIT = 3'h5;
    localparam logic [14:0] CRC_POLY = 15'h4599;
    localparam logic [14:0] CRC_INIT = 15'h0000;

    typedef enum logic [2:0] {
        FLD_IDLE,
        FLD_CRC_COVER,
        FLD_CRC,
        FLD_CRC_DELIM,
        FLD_ACK_SLOT,
        FLD_ACK_DELIM,
        FLD_EOF,
        FLD_ERROR
    } cmow_field_t;

    typedef struct packed {
        logic last;
        logic has_data;
        logic [7:0] data;
    } cmow_rx_item_t;

    typedef struct packed {
        logic [10:0] id;
        logic ide;
        logic rtr;
        logic [3:0] dlc;
        logic [14:0] hits;
    } cmow_rx_hdr_t;
endpackage : cmow_pkg

// ### logic/cmow_window.sv
//  Function
// [RULE_01] page upper nibble selects message object 0..14 for object accesses
// [RULE_02] index auto-increments on data access when control bit is zero
// [RULE_03] page low three bits give byte position in object data
// [RULE_04] page register resets to zero: object 0, index 0, auto-increment
// [RULE_05] config 00 disable, 01 transmit, 10 receive, 11 receive buffer
// [RULE_06] enable bit set only by software rewriting the config field
// [RULE_07] automatic reply to remote frame sent only when reply valid set
// [RULE_08] ide bit zero means 11-bit identifier, one means 29-bit
// [RULE_09] four-bit length code, overwritten by each received frame
// [RULE_10] length warning when received length differs; length stored anyway
// [RULE_11] transmit done flag set on completed transmission, interrupt source
// [RULE_12] lowest indexed transmit object served first
// [RULE_13] receive done flag set on completed reception, interrupt source
// [RULE_14] frame hitting several objects updates lowest index first; the code updates only the lowest-index hit object
// [RULE_15] bit error only while transmitting, arbitration and error ack excepted
// [RULE_16] stuff error on more than five equal consecutive bits
// [RULE_17] crc over destuffed bits compared with received crc field
// [RULE_18] form error on bad crc delimiter, ack delimiter or end of frame
// [RULE_19] ack error when acknowledge slot is not dominant
// [RULE_20] standard id bits 10..3 in high tag, 2..0 in low tag bits 7..5
// [RULE_21] status and tag registers are not initialised by reset
// [RULE_22] auto-increment wraps byte index from seven back to zero
`timescale 1ns/1ns

module cmow_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_i,          // clock
    input wire logic rst_n_i,             // sync reset, active low
    input wire logic in_valid_i,          // write request
    output logic in_ready_o,              // room available
    input wire logic [WIDTH-1:0] in_data_i, // write word
    output logic out_valid_o,             // word available
    input wire logic out_ready_i,         // drain accepts
    output logic [WIDTH-1:0] out_data_o   // head word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic room;
    wire push = in_valid_i && room;
    wire pop = out_valid_o && out_ready_i;
    wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

    assign in_ready_o = room;
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            room <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
            end
            count <= next_count;
            room <= (next_count != CNT_FULL);
        end
    end
endmodule : cmow_fifo

module cmow_window #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic core_clk_i,                  // 100 MHz clock
    input wire logic rst_n_i,                     // sync reset, active low
    input wire logic [7:0] sfr_addr_i,            // sfr address
    input wire logic sfr_wr_i,                    // sfr write strobe
    input wire logic sfr_rd_i,                    // sfr read strobe
    input wire logic [7:0] sfr_wdata_i,           // sfr write data
    output logic [7:0] sfr_rdata_o,               // sfr read data, next cycle
    input wire logic rx_hdr_valid_i,              // received frame header offered
    input wire cmow_pkg::cmow_rx_hdr_t rx_hdr_i,  // header contents
    output logic rx_hdr_ready_o,                  // header accepted
    input wire logic rx_item_valid_i,             // data item offered
    input wire cmow_pkg::cmow_rx_item_t rx_item_i, // data byte, last marker
    output logic rx_item_ready_o,                 // fifo has room
    output logic tx_req_valid_o,                  // transmission requested
    output logic [3:0] tx_obj_o,                  // object to send
    output logic [3:0] tx_dlc_o,                  // its length code
    output logic tx_ide_o,                        // its identifier format
    input wire logic tx_done_i,                   // requested frame sent
    input wire logic bit_sample_i,                // bus sample pulse
    input wire logic bus_bit_i,                   // bus pin level, async
    input wire logic sent_bit_i,                  // level being sent
    input wire logic transmitting_i,              // node is transmitter
    input wire logic arbitration_i,               // in arbitration field
    input wire cmow_pkg::cmow_field_t field_i,    // current frame field
    input wire logic [3:0] err_obj_i,             // object errors belong to
    output logic [cmow_pkg::NUM_OBJ-1:0] obj_enable_o // object enable bits
);
    localparam int N = cmow_pkg::NUM_OBJ;
    localparam int IW = $bits(cmow_pkg::cmow_rx_item_t);

    typedef enum {RX_WAIT_HDR, RX_DATA} cmow_rx_state_t;

    logic [7:0] page;
    logic [7:0] ctrl [N];
    logic [7:0] status [N];
    logic [7:0] idt_high [N];
    logic [2:0] idt_low [N];
    logic [7:0] data [N][cmow_pkg::DATA_BYTES];
    logic [N-1:0] reply_pend;
    logic bus_meta;
    logic bus_bit;
    cmow_rx_state_t rx_state;
    cmow_pkg::cmow_rx_hdr_t hdr;
    logic rx_found;
    logic [3:0] rx_obj;
    logic [2:0] rx_ptr;
    logic [2:0] run_cnt;
    logic last_bit;
    logic [14:0] crc;
    logic [14:0] crc_rx;

    // page fields
    wire [3:0] sel_obj = page[7:cmow_pkg::PAGE_OBJ_LSB]; // RULE_01
    wire sel_ok = (sel_obj < 4'(N));
    wire [2:0] sel_idx = page[2:0]; // RULE_03
    wire autoinc = !page[cmow_pkg::PAGE_INDEX_AUTOINC_N_BIT]; // RULE_02
    wire wr_page = sfr_wr_i && (sfr_addr_i == cmow_pkg::ADDR_PAGE);
    wire wr_status = sfr_wr_i && sel_ok && (sfr_addr_i == cmow_pkg::ADDR_STATUS);
    wire wr_ctrl = sfr_wr_i && sel_ok && (sfr_addr_i == cmow_pkg::ADDR_CTRL);
    wire wr_idh = sfr_wr_i && sel_ok && (sfr_addr_i == cmow_pkg::ADDR_IDT_HIGH);
    wire wr_idl = sfr_wr_i && sel_ok && (sfr_addr_i == cmow_pkg::ADDR_IDT_LOW);
    wire data_hit = (sfr_addr_i == cmow_pkg::ADDR_DATA) && (sfr_wr_i || sfr_rd_i);
    wire wr_data = sfr_wr_i && sel_ok && (sfr_addr_i == cmow_pkg::ADDR_DATA);

    // receive drain from the fifo
    cmow_pkg::cmow_rx_item_t item;
    logic item_valid;
    wire item_ready = (rx_state == RX_DATA);
    wire item_take = item_valid && item_ready;
    wire rx_complete = item_take && item.last && rx_found;

    cmow_fifo #(
        .WIDTH(IW),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(rx_item_valid_i),
        .in_ready_o(rx_item_ready_o),
        .in_data_i(rx_item_i),
        .out_valid_o(item_valid),
        .out_ready_i(item_ready),
        .out_data_o(item)
    );

    // lowest-index selection for reception and transmission
    logic [N-1:0] rx_cand;
    logic [N-1:0] tx_cand;
    logic [3:0] rx_sel;
    logic [3:0] tx_sel;
    always_comb begin
        rx_sel = '0;
        tx_sel = '0;
        for (int i = 0; i < N; i++) begin
            rx_cand[i] = rx_hdr_i.hits[i] && obj_enable_o[i] && ctrl[i][7]; // RULE_05
            tx_cand[i] = obj_enable_o[i] && ((ctrl[i][7:6] == cmow_pkg::CFG_TX) || reply_pend[i]); // RULE_05
        end
        for (int i = N - 1; i >= 0; i--) begin
            if (rx_cand[i]) begin
                rx_sel = 4'(i); // RULE_14
            end
            if (tx_cand[i]) begin
                tx_sel = 4'(i); // RULE_12
            end
        end
    end

    // bit-level checks on the synchronised bus level
    wire stuffed = (field_i == cmow_pkg::FLD_CRC_COVER) || (field_i == cmow_pkg::FLD_CRC);
    wire is_stuff = stuffed && (run_cnt == cmow_pkg::STUFF_LIMIT);
    wire stuff_err = bit_sample_i && is_stuff && (bus_bit == last_bit); // RULE_16
    wire crc_fb = bus_bit ^ crc[14];
    wire [14:0] crc_step = {crc[13:0], 1'b0} ^ (crc_fb ? cmow_pkg::CRC_POLY : 15'h0000);
    wire crc_err = bit_sample_i && (field_i == cmow_pkg::FLD_CRC_DELIM) && (crc_rx != crc); // RULE_17
    wire delim = (field_i == cmow_pkg::FLD_CRC_DELIM) || (field_i == cmow_pkg::FLD_ACK_DELIM)
        || (field_i == cmow_pkg::FLD_EOF);
    wire form_err = bit_sample_i && delim && !bus_bit; // RULE_18
    wire ack_err = bit_sample_i && transmitting_i && (field_i == cmow_pkg::FLD_ACK_SLOT) && bus_bit; // RULE_19
    wire arb_lost = arbitration_i && sent_bit_i && !bus_bit;
    wire err_ack = (field_i == cmow_pkg::FLD_ACK_SLOT) || ((field_i == cmow_pkg::FLD_ERROR) && !bus_bit);
    wire bit_err = bit_sample_i && transmitting_i && (bus_bit != sent_bit_i) && !arb_lost && !err_ack; // RULE_15
    wire [7:0] err_set = {3'h0, bit_err, stuff_err, crc_err, form_err, ack_err};

    always_ff @(posedge core_clk_i) begin
        bus_meta <= bus_bit_i;
        bus_bit <= bus_meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || field_i == cmow_pkg::FLD_IDLE) begin
            run_cnt <= '0;
            last_bit <= 1'b1;
            crc <= cmow_pkg::CRC_INIT;
            crc_rx <= '0;
        end else if (bit_sample_i && stuffed) begin
            last_bit <= bus_bit;
            if (is_stuff) begin
                run_cnt <= 3'h1;
            end else begin
                run_cnt <= (bus_bit == last_bit) ? run_cnt + 3'h1 : 3'h1;
                if (field_i == cmow_pkg::FLD_CRC_COVER) begin
                    crc <= crc_step; // RULE_17
                end else begin
                    crc_rx <= {crc_rx[13:0], bus_bit};
                end
            end
        end
    end

    // page register and data index
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            page <= cmow_pkg::PAGE_RESET; // RULE_04
        end else if (wr_page) begin
            page <= sfr_wdata_i;
        end else if (data_hit && autoinc) begin
            page[2:0] <= sel_idx + 3'h1; // RULE_02 RULE_22
        end
    end

    // per-object control, enable and reply state
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < N; i++) begin
                ctrl[i] <= cmow_pkg::CTRL_RESET;
            end
            obj_enable_o <= '0;
            reply_pend <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl[sel_obj] <= sfr_wdata_i;
                obj_enable_o[sel_obj] <= (sfr_wdata_i[7:6] != cmow_pkg::CFG_DISABLE); // RULE_06
                reply_pend[sel_obj] <= 1'b0;
            end
            if (tx_done_i && tx_req_valid_o) begin
                obj_enable_o[tx_obj_o] <= 1'b0;
                reply_pend[tx_obj_o] <= 1'b0;
            end
            if (rx_complete) begin
                ctrl[rx_obj][3:0] <= hdr.dlc; // RULE_09 RULE_10
                ctrl[rx_obj][cmow_pkg::IDE_BIT] <= hdr.ide; // RULE_08
                if (hdr.rtr && ctrl[rx_obj][cmow_pkg::REPLY_VALID_BIT]) begin
                    reply_pend[rx_obj] <= 1'b1; // RULE_07
                end else if (ctrl[rx_obj][7:6] == cmow_pkg::CFG_RX) begin
                    obj_enable_o[rx_obj] <= 1'b0;
                end
            end
        end
    end

    // status and tags: no reset, hardware set wins over software write
    always_ff @(posedge core_clk_i) begin // RULE_21
        for (int i = 0; i < N; i++) begin
            logic [7:0] set_bits;
            set_bits = '0;
            if (err_obj_i == 4'(i)) begin
                set_bits = set_bits | err_set;
            end
            if (tx_done_i && tx_req_valid_o && tx_obj_o == 4'(i)) begin
                set_bits[cmow_pkg::ST_TX_DONE] = 1'b1; // RULE_11
            end
            if (rx_complete && rx_obj == 4'(i)) begin
                set_bits[cmow_pkg::ST_RX_DONE] = 1'b1; // RULE_13
                set_bits[cmow_pkg::ST_LEN_WARN] = (hdr.dlc != ctrl[i][3:0]); // RULE_10
            end
            status[i] <= ((wr_status && sel_obj == 4'(i)) ? sfr_wdata_i : status[i]) | set_bits;
        end
        if (wr_idh) begin
            idt_high[sel_obj] <= sfr_wdata_i; // RULE_20
        end
        if (wr_idl) begin
            idt_low[sel_obj] <= sfr_wdata_i[7:cmow_pkg::IDT_LOW_LSB]; // RULE_20
        end
        if (rx_complete && !hdr.ide) begin
            idt_high[rx_obj] <= hdr.id[10:3];
            idt_low[rx_obj] <= hdr.id[2:0];
        end
        if (wr_data) begin
            data[sel_obj][sel_idx] <= sfr_wdata_i; // RULE_03
        end
        if (item_take && item.has_data && rx_found) begin
            data[rx_obj][rx_ptr] <= item.data;
        end
    end

    // receive sequencing
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_state <= RX_WAIT_HDR;
            rx_hdr_ready_o <= 1'b1;
            rx_found <= 1'b0;
            rx_obj <= '0;
            rx_ptr <= '0;
            hdr <= '0;
        end else begin
            unique case (rx_state)
                RX_WAIT_HDR: begin
                    if (rx_hdr_valid_i) begin
                        hdr <= rx_hdr_i;
                        rx_found <= |rx_cand;
                        rx_obj <= rx_sel; // RULE_14
                        rx_ptr <= '0;
                        rx_state <= RX_DATA;
                        rx_hdr_ready_o <= 1'b0;
                    end
                end
                RX_DATA: begin
                    if (item_take) begin
                        if (item.has_data) begin
                            rx_ptr <= rx_ptr + 3'h1;
                        end
                        if (item.last) begin
                            rx_state <= RX_WAIT_HDR;
                            rx_hdr_ready_o <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // transmission request
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_req_valid_o <= 1'b0;
            tx_obj_o <= '0;
            tx_dlc_o <= '0;
            tx_ide_o <= 1'b0;
        end else if (tx_req_valid_o) begin
            if (tx_done_i) begin
                tx_req_valid_o <= 1'b0;
            end
        end else if (|tx_cand) begin
            tx_req_valid_o <= 1'b1;
            tx_obj_o <= tx_sel; // RULE_12
            tx_dlc_o <= ctrl[tx_sel][3:0];
            tx_ide_o <= ctrl[tx_sel][cmow_pkg::IDE_BIT]; // RULE_08
        end
    end

    // read data, one cycle after the strobe
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        if (sfr_addr_i == cmow_pkg::ADDR_PAGE) begin
            rd_mux = page;
        end else if (sel_ok) begin
            unique case (sfr_addr_i)
                cmow_pkg::ADDR_STATUS: rd_mux = status[sel_obj];
                cmow_pkg::ADDR_CTRL: rd_mux = ctrl[sel_obj];
                cmow_pkg::ADDR_IDT_HIGH: rd_mux = idt_high[sel_obj];
                cmow_pkg::ADDR_IDT_LOW: rd_mux = {idt_low[sel_obj], 5'h00};
                cmow_pkg::ADDR_DATA: rd_mux = data[sel_obj][sel_idx];
                default: rd_mux = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= '0;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= rd_mux;
        end
    end
endmodule : cmow_window

// ### testbench/cmow_window_monitor.sv
`timescale 1ns/1ns
module cmow_window_monitor (
    input wire logic core_clk_i, // clock
    input wire logic rst_n_i, // sync reset, active low
    input wire logic sfr_rd_i, // read strobe
    input wire logic [7:0] sfr_rdata_o, // read data
    input wire logic rx_hdr_valid_i, // header offered
    input wire logic rx_hdr_ready_o, // header accepted
    input wire logic rx_item_ready_o, // fifo room
    input wire logic tx_req_valid_o, // send request
    input wire logic [3:0] tx_obj_o, // object to send
    input wire logic [3:0] tx_dlc_o, // its length code
    input wire logic tx_done_i, // frame sent
    input wire logic [14:0] obj_enable_o // enable bits
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_rst_vals;
        $rose(rst_n_i) |-> rx_hdr_ready_o && rx_item_ready_o && !tx_req_valid_o && obj_enable_o == 15'h0000;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("state after reset wrong");
    property p_tx_hold;
        tx_req_valid_o && !tx_done_i |=> tx_req_valid_o && $stable(tx_obj_o) && $stable(tx_dlc_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("send request not held");
    property p_tx_drop;
        tx_req_valid_o && tx_done_i |=> !tx_req_valid_o && !obj_enable_o[$past(tx_obj_o)];
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("request or enable not cleared after send");
    property p_tx_range;
        tx_req_valid_o |-> tx_obj_o < 4'hf;
    endproperty
    a_tx_range: assert property (p_tx_range) else $error("object number out of range");
    property p_hdr_take;
        rx_hdr_valid_i && rx_hdr_ready_o |=> !rx_hdr_ready_o;
    endproperty
    a_hdr_take: assert property (p_hdr_take) else $error("header ready not dropped");
    property p_hdr_back;
        rx_hdr_valid_i && rx_hdr_ready_o |-> ##[2:60] rx_hdr_ready_o;
    endproperty
    a_hdr_back: assert property (p_hdr_back) else $error("frame never completed");
    property p_rd_hold;
        !sfr_rd_i |=> $stable(sfr_rdata_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
    property p_fifo_drain;
        !rx_item_ready_o |-> ##[1:40] rx_item_ready_o;
    endproperty
    a_fifo_drain: assert property (p_fifo_drain) else $error("fifo never drains");
endmodule : cmow_window_monitor

bind cmow_window cmow_window_monitor u_mon (.core_clk_i, .rst_n_i, .sfr_rd_i, .sfr_rdata_o, .rx_hdr_valid_i,
    .rx_hdr_ready_o, .rx_item_ready_o, .tx_req_valid_o, .tx_obj_o, .tx_dlc_o, .tx_done_i, .obj_enable_o);

// ### testbench/cmow_can_node.sv
`timescale 1ns/1ns
module cmow_can_node #(
    parameter int TX_DELAY = 40
) (
    input wire logic core_clk_i, // clock
    output logic rx_hdr_valid_o, // header offered
    output cmow_pkg::cmow_rx_hdr_t rx_hdr_o, // header
    input wire logic rx_hdr_ready_i, // header taken
    output logic rx_item_valid_o, // item offered
    output cmow_pkg::cmow_rx_item_t rx_item_o, // data item
    input wire logic rx_item_ready_i, // item taken
    input wire logic tx_req_valid_i, // send request
    output logic tx_done_o // frame sent
);
    initial begin
        rx_hdr_valid_o = 1'b0;
        rx_item_valid_o = 1'b0;
        tx_done_o = 1'b0;
        rx_hdr_o = '0;
        rx_item_o = '0;
    end
    // header first, then bytes; released lines show inverted values
    task automatic send(input cmow_pkg::cmow_rx_hdr_t h, input logic [7:0] dv [8], input int n);
        @(posedge core_clk_i);
        rx_hdr_o <= h;
        rx_hdr_valid_o <= 1'b1;
        do @(posedge core_clk_i); while (rx_hdr_ready_i !== 1'b1);
        rx_hdr_valid_o <= 1'b0;
        rx_hdr_o <= ~h;
        for (int i = 0; i < n; i++) begin
            rx_item_o <= '{last: (i == n - 1), has_data: 1'b1, data: dv[i]};
            rx_item_valid_o <= 1'b1;
            do @(posedge core_clk_i); while (rx_item_ready_i !== 1'b1);
        end
        rx_item_valid_o <= 1'b0;
        rx_item_o <= ~rx_item_o;
    endtask : send
    // slow bus: each requested frame takes TX_DELAY cycles
    initial forever begin
        @(posedge core_clk_i);
        if (tx_req_valid_i === 1'b1) begin
            repeat (TX_DELAY) @(posedge core_clk_i);
            tx_done_o <= 1'b1;
            @(posedge core_clk_i);
            tx_done_o <= 1'b0;
            @(posedge core_clk_i);
        end
    end
endmodule : cmow_can_node

// ### testbench/tb_cmow_window.sv
`timescale 1ns/1ns
module tb_cmow_window;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic wr = 1'b0, rd = 1'b0, hv, hr, iv, ir, txv, txide, txdone;
    logic bs = 1'b0, bb = 1'b1, sb = 1'b1, txing = 1'b0, arb = 1'b0;
    logic [3:0] txobj, txdlc, eobj = 4'hf;
    logic [14:0] en;
    cmow_pkg::cmow_rx_hdr_t hdr, h;
    cmow_pkg::cmow_rx_item_t item;
    cmow_pkg::cmow_field_t fld = cmow_pkg::FLD_IDLE;
    logic [31:0] seed = 32'h20ee1ed4;
    logic [7:0] d [8];
    int errors = 0, checks_done = 0;
    always #5 core_clk_i = ~core_clk_i;
    cmow_window #(.FIFO_DEPTH(4)) uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .rx_hdr_valid_i(hv),
        .rx_hdr_i(hdr), .rx_hdr_ready_o(hr), .rx_item_valid_i(iv), .rx_item_i(item), .rx_item_ready_o(ir),
        .tx_req_valid_o(txv), .tx_obj_o(txobj), .tx_dlc_o(txdlc), .tx_ide_o(txide), .tx_done_i(txdone),
        .bit_sample_i(bs), .bus_bit_i(bb), .sent_bit_i(sb), .transmitting_i(txing), .arbitration_i(arb),
        .field_i(fld), .err_obj_i(eobj), .obj_enable_o(en));
    cmow_can_node node (.core_clk_i(core_clk_i), .rx_hdr_valid_o(hv), .rx_hdr_o(hdr), .rx_hdr_ready_i(hr),
        .rx_item_valid_o(iv), .rx_item_o(item), .rx_item_ready_i(ir), .tx_req_valid_i(txv), .tx_done_o(txdone));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd
    task automatic finish_test();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_i);
        rd <= 1'b0;
        @(posedge core_clk_i);
        #1 check(rdata, e);
    endtask : rd_check
    task automatic obj_wr(input logic [3:0] o, input logic [7:0] a, input logic [7:0] v);
        wr_reg(cmow_pkg::ADDR_PAGE, {o, 4'h0});
        wr_reg(a, v);
    endtask : obj_wr
    task automatic obj_rd(input logic [3:0] o, input logic [7:0] a, input logic [7:0] e);
        wr_reg(cmow_pkg::ADDR_PAGE, {o, 4'h0});
        rd_check(a, e);
    endtask : obj_rd
    task automatic wait_tx(input logic [3:0] o, input logic [3:0] l, input logic ide);
        int k = 0;
        while (txv !== 1'b1 && k < 300) begin
            @(posedge core_clk_i);
            #1 k++;
        end
        check({txobj, txdlc}, {o, l});
        check({txv, 6'h00, txide}, {1'b1, 6'h00, ide});
        while (txv === 1'b1 && k < 600) begin
            @(posedge core_clk_i);
            #1 k++;
        end
    endtask : wait_tx
    // each bus bit is stable three cycles before its sample pulse
    task automatic bits(input int n, input logic v);
        repeat (n) begin
            @(posedge core_clk_i);
            bb <= v;
            sb <= v;
            repeat (3) @(posedge core_clk_i);
            bs <= 1'b1;
            @(posedge core_clk_i);
            bs <= 1'b0;
        end
    endtask : bits
    initial begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd_check(cmow_pkg::ADDR_PAGE, 8'h00);
        check(en[7:0], 8'h00);
        for (int i = 0; i < 8; i++) d[i] = rnd();
        wr_reg(cmow_pkg::ADDR_PAGE, 8'h56);
        for (int i = 0; i < 3; i++) wr_reg(cmow_pkg::ADDR_DATA, d[i]);
        rd_check(cmow_pkg::ADDR_PAGE, 8'h51);
        wr_reg(cmow_pkg::ADDR_PAGE, 8'h56);
        for (int i = 0; i < 3; i++) rd_check(cmow_pkg::ADDR_DATA, d[i]);
        wr_reg(cmow_pkg::ADDR_PAGE, 8'h5e);
        rd_check(cmow_pkg::ADDR_DATA, d[0]);
        rd_check(cmow_pkg::ADDR_PAGE, 8'h5e);
        obj_wr(4'hf, cmow_pkg::ADDR_CTRL, 8'h80);
        rd_check(cmow_pkg::ADDR_CTRL, 8'h00);
        obj_wr(4'h5, cmow_pkg::ADDR_STATUS, 8'h00);
        obj_wr(4'h5, cmow_pkg::ADDR_CTRL, 8'h48);
        obj_wr(4'h3, cmow_pkg::ADDR_CTRL, 8'h42);
        obj_wr(4'h1, cmow_pkg::ADDR_CTRL, 8'h53);
        obj_wr(4'h2, cmow_pkg::ADDR_CTRL, 8'h84);
        obj_wr(4'h4, cmow_pkg::ADDR_CTRL, 8'hc4);
        obj_wr(4'h2, cmow_pkg::ADDR_STATUS, 8'h00);
        wait_tx(4'h5, 4'h8, 1'b0);
        wait_tx(4'h1, 4'h3, 1'b1);
        wait_tx(4'h3, 4'h2, 1'b0);
        obj_rd(4'h5, cmow_pkg::ADDR_STATUS, 8'h40);
        check({1'b0, en[6:0]}, 8'h14);
        h = '{id: {d[7][2:0], rnd()}, ide: 1'b0, rtr: 1'b0, dlc: 4'h3, hits: 15'h0014};
        node.send(h, d, 3);
        repeat (10) @(posedge core_clk_i);
        obj_rd(4'h2, cmow_pkg::ADDR_STATUS, 8'ha0);
        obj_rd(4'h2, cmow_pkg::ADDR_IDT_HIGH, h.id[10:3]);
        rd_check(cmow_pkg::ADDR_IDT_LOW, {h.id[2:0], 5'h00});
        for (int i = 0; i < 3; i++) rd_check(cmow_pkg::ADDR_DATA, d[i]);
        rd_check(cmow_pkg::ADDR_CTRL, 8'h83);
        check({3'h0, en[4:0]}, 8'h10);
        obj_wr(4'h6, cmow_pkg::ADDR_STATUS, 8'h00);
        obj_wr(4'h7, cmow_pkg::ADDR_STATUS, 8'h00);
        eobj <= 4'h6;
        fld <= cmow_pkg::FLD_CRC_COVER;
        bits(7, 1'b0);
        fld <= cmow_pkg::FLD_IDLE;
        @(posedge core_clk_i);
        eobj <= 4'h7;
        txing <= 1'b1;
        fld <= cmow_pkg::FLD_ACK_SLOT;
        bits(1, 1'b1);
        fld <= cmow_pkg::FLD_ACK_DELIM;
        bits(1, 1'b0);
        fld <= cmow_pkg::FLD_IDLE;
        txing <= 1'b0;
        obj_rd(4'h6, cmow_pkg::ADDR_STATUS, 8'h08);
        obj_rd(4'h7, cmow_pkg::ADDR_STATUS, 8'h03);
        finish_test();
    end
endmodule : tb_cmow_window
